// *** logic/pms_sequencer.sv ***
// Measurement sequencer, result math, averaging and alert of a power monitor
// Function
// - Continuous mode 111 repeats shunt then bus
// - Current is shunt scaled by calibration register
// - Power from new bus and latest current
// - Accumulate sequences, average, then update outputs
// - Outputs hold until next averaging completes
// - Register reads never disturb running conversions
// - Shunt-only and bus-only modes skip other channel
// - Math runs alongside, adds no conversion time
// - Triggered codes run one full cycle, stop
// - Every triggered write starts a fresh cycle
// - Power-down halts conversions, registers stay accessible
// - Done flag only after whole cycle finished
// - Done cleared by active config write, mask read
// - Current reads zero until calibration written
// - Power reads zero until calibration written
// - Outputs per sequence only when averaging is one
// - Bus code weight 1.25mV, 40.96V span
// - Alert selects ready or one limit check
// - Compare selected quantity against alert limit
// - Highest enabled limit bit wins
// - Latch keeps flag and alert until mask read
// - Alert polarity bit sets active level
// - Ready-on-alert asserts alert when done sets
`timescale 1ns/10ps
module pms_sequencer (
  input wire logic clk_i, // Core clock, 20 MHz
  input wire logic reset_n_i, // Async reset, active low
  input wire logic reg_wr_i, // Register write strobe
  input wire logic reg_rd_i, // Register read strobe
  input wire logic [7:0] reg_addr_i, // Register pointer
  input wire logic [15:0] reg_wdata_i, // Write data
  output logic [15:0] reg_rdata_o, // Read data, next cycle
  input wire logic adc_clk_i, // Converter clock
  output logic adc_start_o, // Conversion start pulse
  output pms_pkg::pms_adc_req_s adc_req_o, // Channel and time
  input wire logic adc_done_i, // Conversion finished pulse
  input wire logic [15:0] adc_data_i, // Conversion result
  output logic alert_o, // Open-drain alert data, low
  output logic alert_oe_o // Open-drain alert enable
);
  pms_pkg::pms_state_e state_ff;
  logic [15:0] cfg_ff, cal_ff, mask_ff, lim_ff, rdata_ff;
  logic [15:0] shunt_raw_ff, bus_raw_ff;
  logic [15:0] res_sh_ff, res_bu_ff, res_cu_ff, res_pw_ff;
  logic signed [pms_pkg::ACC_W-1:0] acc_sh_ff, acc_bu_ff;
  logic signed [pms_pkg::ACC_W-1:0] acc_cu_ff, acc_pw_ff;
  logic [pms_pkg::SEQ_W-1:0] seq_cnt_ff;
  logic busy_ff, single_ff, cal_wr_ff, done_ff, aff_ff, alert_oe_ff;
  logic req_tgl_ff, ack_meta_ff, ack_sync_ff, ack_seen_ff;
  pms_pkg::pms_adc_req_s req_word_ff;
  logic rq_meta_ff, rq_sync_ff, rq_seen_ff, ack_tgl_ff, adc_start_ff;
  logic adc_wait_ff;
  pms_pkg::pms_adc_req_s adc_req_ff;
  logic [15:0] adc_data_ff;

  logic [2:0] mode;
  logic [3:0] avg_sh;
  logic cfg_wr, mask_rd, pd_mode, run, ack_evt, send_req, send_bus;
  logic avg_last, cond, alert_act, rq_new;
  logic signed [32:0] cur_prod;
  logic [15:0] cur_calc, cur_mag, pwr_calc, bus_sat;
  logic [31:0] pwr_prod;
  logic signed [pms_pkg::ACC_W-1:0] avg_sh_w, avg_bu_w, avg_cu_w, avg_pw_w;

  assign mode = cfg_ff[pms_pkg::CFG_MODE_LSB +: 3];
  assign avg_sh = pms_pkg::avg_shift(cfg_ff[pms_pkg::CFG_AVG_LSB +: 3]);
  assign cfg_wr = reg_wr_i && (reg_addr_i == pms_pkg::ADDR_CFG);
  assign mask_rd = reg_rd_i && (reg_addr_i == pms_pkg::ADDR_MASK);
  // Code 100 names no channel, so it also counts as power-down
  assign pd_mode = (mode[1:0] == 2'b00);
  assign run = !pd_mode && (mode[pms_pkg::MODE_CONT_BIT] || single_ff);
  assign ack_evt = ack_sync_ff ^ ack_seen_ff;
  assign avg_last =
    (seq_cnt_ff == pms_pkg::SEQ_W'((11'h1 << avg_sh) - 11'h1));

  // Bus conversion leaves as soon as the shunt result lands
  assign send_bus = (state_ff == pms_pkg::ST_SHUNT) && ack_evt &&
                    mode[pms_pkg::MODE_BUS_BIT];
  assign send_req = !cfg_wr && (send_bus ||
                    ((state_ff == pms_pkg::ST_IDLE) && !busy_ff && run));

  // Current and power are plain combinational math on held samples
  assign cur_prod = $signed(shunt_raw_ff) * $signed({1'b0, cal_ff});
  assign cur_calc = cur_prod[pms_pkg::CUR_SHIFT +: 16];
  assign cur_mag = cur_calc[15] ? 16'(-cur_calc) : cur_calc;
  assign pwr_prod = cur_mag * bus_raw_ff;
  assign pwr_calc = pwr_prod[pms_pkg::PWR_SHIFT +: 16];
  assign bus_sat = (adc_data_ff > pms_pkg::BUS_MAX_CODE) ?
                   pms_pkg::BUS_MAX_CODE : adc_data_ff;

  assign avg_sh_w = acc_sh_ff >>> avg_sh;
  assign avg_bu_w = acc_bu_ff >>> avg_sh;
  assign avg_cu_w = acc_cu_ff >>> avg_sh;
  assign avg_pw_w = acc_pw_ff >>> avg_sh;

  // Highest enabled limit check is the only one evaluated
  always_comb
  begin
    if (mask_ff[pms_pkg::MSK_SOL])
      cond = $signed(avg_sh_w[15:0]) > $signed(lim_ff);
    else if (mask_ff[pms_pkg::MSK_SUL])
      cond = $signed(avg_sh_w[15:0]) < $signed(lim_ff);
    else if (mask_ff[pms_pkg::MSK_BOL])
      cond = avg_bu_w[15:0] > lim_ff;
    else if (mask_ff[pms_pkg::MSK_BUL])
      cond = avg_bu_w[15:0] < lim_ff;
    else if (mask_ff[pms_pkg::MSK_POL])
      cond = avg_pw_w[15:0] > lim_ff;
    else
      cond = 1'b0;
  end

  assign alert_act = aff_ff ||
    (mask_ff[pms_pkg::MSK_READY_ON_ALERT_ENABLE] && done_ff);

  // Sequencer
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state_ff <= pms_pkg::ST_IDLE;
    else if (cfg_wr)
      state_ff <= pms_pkg::ST_IDLE;
    else
      case (state_ff)
        pms_pkg::ST_IDLE:
          if (send_req)
            state_ff <= mode[pms_pkg::MODE_SHUNT_BIT] ?
                        pms_pkg::ST_SHUNT : pms_pkg::ST_BUS;
        pms_pkg::ST_SHUNT:
          if (ack_evt)
            state_ff <= mode[pms_pkg::MODE_BUS_BIT] ?
                        pms_pkg::ST_BUS : pms_pkg::ST_ACC;
        pms_pkg::ST_BUS:
          if (ack_evt)
            state_ff <= pms_pkg::ST_ACC;
        pms_pkg::ST_ACC:
          state_ff <= avg_last ? pms_pkg::ST_AVG : pms_pkg::ST_IDLE;
        default:
          state_ff <= pms_pkg::ST_IDLE;
      endcase
  end

  // A late result after an abort only clears busy, it is never used
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      busy_ff <= 1'b0;
    else
      busy_ff <= send_req || (busy_ff && !ack_evt);
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      single_ff <= 1'b0;
    else if (cfg_wr)
      single_ff <= !reg_wdata_i[pms_pkg::MODE_CONT_BIT] &&
                   (reg_wdata_i[1:0] != 2'b00);
    else if (state_ff == pms_pkg::ST_AVG)
      single_ff <= 1'b0;
  end

  // Sample capture and accumulation
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      shunt_raw_ff <= 16'h0000;
      bus_raw_ff <= 16'h0000;
    end
    else if (ack_evt && (state_ff == pms_pkg::ST_SHUNT))
      shunt_raw_ff <= adc_data_ff;
    else if (ack_evt && (state_ff == pms_pkg::ST_BUS))
      bus_raw_ff <= bus_sat;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      acc_sh_ff <= '0;
      acc_bu_ff <= '0;
      acc_cu_ff <= '0;
      acc_pw_ff <= '0;
      seq_cnt_ff <= '0;
    end
    else if (cfg_wr || (state_ff == pms_pkg::ST_AVG))
    begin
      acc_sh_ff <= '0;
      acc_bu_ff <= '0;
      acc_cu_ff <= '0;
      acc_pw_ff <= '0;
      seq_cnt_ff <= '0;
    end
    else if (state_ff == pms_pkg::ST_ACC)
    begin
      acc_sh_ff <= acc_sh_ff +
                   pms_pkg::ACC_W'($signed(shunt_raw_ff));
      acc_bu_ff <= acc_bu_ff + pms_pkg::ACC_W'({1'b0, bus_raw_ff});
      acc_cu_ff <= acc_cu_ff + pms_pkg::ACC_W'($signed(cur_calc));
      acc_pw_ff <= acc_pw_ff + pms_pkg::ACC_W'({1'b0, pwr_calc});
      seq_cnt_ff <= seq_cnt_ff + 1'b1;
    end
  end

  // Output registers only move at the end of an averaging cycle
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      res_sh_ff <= 16'h0000;
      res_bu_ff <= 16'h0000;
      res_cu_ff <= 16'h0000;
      res_pw_ff <= 16'h0000;
    end
    else if (state_ff == pms_pkg::ST_AVG)
    begin
      res_sh_ff <= avg_sh_w[15:0];
      res_bu_ff <= avg_bu_w[15:0];
      res_cu_ff <= avg_cu_w[15:0];
      res_pw_ff <= avg_pw_w[15:0];
    end
  end

  // Flags: a setting event wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      done_ff <= 1'b0;
    else if (state_ff == pms_pkg::ST_AVG)
      done_ff <= 1'b1;
    else if ((cfg_wr && (reg_wdata_i[1:0] != 2'b00)) || mask_rd)
      done_ff <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      aff_ff <= 1'b0;
    else if (state_ff == pms_pkg::ST_AVG)
      aff_ff <= cond ||
        (aff_ff && mask_ff[pms_pkg::MSK_LEN] && !mask_rd);
    else if (mask_rd && mask_ff[pms_pkg::MSK_LEN])
      aff_ff <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      alert_oe_ff <= 1'b0;
    else
      alert_oe_ff <= alert_act ^ mask_ff[pms_pkg::MSK_ALERT_POLARITY];
  end

  // Register file; writes stay open in every mode
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cfg_ff <= pms_pkg::CFG_RESET;
      cal_ff <= 16'h0000;
      cal_wr_ff <= 1'b0;
      mask_ff <= pms_pkg::MSK_RESET;
      lim_ff <= 16'h0000;
    end
    else if (reg_wr_i)
      case (reg_addr_i)
        pms_pkg::ADDR_CFG: cfg_ff <= reg_wdata_i & pms_pkg::CFG_WR_MASK;
        pms_pkg::ADDR_CAL:
        begin
          cal_ff <= reg_wdata_i;
          cal_wr_ff <= 1'b1;
        end
        pms_pkg::ADDR_MASK: mask_ff <= reg_wdata_i & pms_pkg::MSK_WR_MASK;
        pms_pkg::ADDR_LIM: lim_ff <= reg_wdata_i;
        default: lim_ff <= lim_ff;
      endcase
  end

  // Reads only sample held results, so a conversion never notices them
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_ff <= 16'h0000;
    else if (reg_rd_i)
      case (reg_addr_i)
        pms_pkg::ADDR_CFG: rdata_ff <= cfg_ff;
        pms_pkg::ADDR_SHUNT: rdata_ff <= res_sh_ff;
        pms_pkg::ADDR_BUS: rdata_ff <= res_bu_ff;
        pms_pkg::ADDR_PWR: rdata_ff <= cal_wr_ff ? res_pw_ff : 16'h0000;
        pms_pkg::ADDR_CUR: rdata_ff <= cal_wr_ff ? res_cu_ff : 16'h0000;
        pms_pkg::ADDR_CAL: rdata_ff <= cal_ff;
        pms_pkg::ADDR_MASK:
          rdata_ff <= {mask_ff[15:10], 5'h00, aff_ff, done_ff, 1'b0,
                       mask_ff[1:0]};
        pms_pkg::ADDR_LIM: rdata_ff <= lim_ff;
        default: rdata_ff <= 16'h0000;
      endcase
  end

  // Request crossing: toggle plus a word held until the answer returns
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      req_tgl_ff <= 1'b0;
      req_word_ff <= '0;
    end
    else if (send_req)
    begin
      req_tgl_ff <= !req_tgl_ff;
      req_word_ff.bus_chan <= send_bus || !mode[pms_pkg::MODE_SHUNT_BIT];
      req_word_ff.conv_time <= (send_bus ||
        !mode[pms_pkg::MODE_SHUNT_BIT]) ?
        cfg_ff[pms_pkg::CFG_BCT_LSB +: 3] :
        cfg_ff[pms_pkg::CFG_SCT_LSB +: 3];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ack_meta_ff <= 1'b0;
      ack_sync_ff <= 1'b0;
      ack_seen_ff <= 1'b0;
    end
    else
    begin
      ack_meta_ff <= ack_tgl_ff;
      ack_sync_ff <= ack_meta_ff;
      ack_seen_ff <= ack_sync_ff;
    end
  end

  // Converter clock domain
  assign rq_new = rq_sync_ff ^ rq_seen_ff;

  always_ff @(posedge adc_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rq_meta_ff <= 1'b0;
      rq_sync_ff <= 1'b0;
      rq_seen_ff <= 1'b0;
    end
    else
    begin
      rq_meta_ff <= req_tgl_ff;
      rq_sync_ff <= rq_meta_ff;
      rq_seen_ff <= rq_sync_ff;
    end
  end

  always_ff @(posedge adc_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      adc_start_ff <= 1'b0;
      adc_req_ff <= '0;
      adc_wait_ff <= 1'b0;
      adc_data_ff <= 16'h0000;
      ack_tgl_ff <= 1'b0;
    end
    else
    begin
      adc_start_ff <= rq_new;
      if (rq_new)
      begin
        adc_req_ff <= req_word_ff;
        adc_wait_ff <= 1'b1;
      end
      else if (adc_wait_ff && adc_done_i)
      begin
        adc_data_ff <= adc_data_i;
        adc_wait_ff <= 1'b0;
        ack_tgl_ff <= !ack_tgl_ff;
      end
    end
  end

  assign adc_start_o = adc_start_ff;
  assign adc_req_o = adc_req_ff;
  assign reg_rdata_o = rdata_ff;
  assign alert_o = 1'b0;
  assign alert_oe_o = alert_oe_ff;

  sequence s_last_acc;
    (state_ff == pms_pkg::ST_ACC) && avg_last && !cfg_wr;
  endsequence
  sequence s_avg_step;
    state_ff == pms_pkg::ST_AVG;
  endsequence

  a_done_after_avg: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_last_acc ##1 s_avg_step |=> done_ff)
    else $error("done flag missing after averaging");
  a_done_only_avg: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(done_ff) |-> $past(state_ff) == pms_pkg::ST_AVG)
    else $error("done flag rose outside averaging");
  a_done_clr_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    mask_rd && (state_ff != pms_pkg::ST_AVG) |=> !done_ff)
    else $error("done flag not cleared by mask read");
  a_result_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state_ff != pms_pkg::ST_AVG) |=> $stable(res_sh_ff) && $stable(res_bu_ff) &&
    $stable(res_cu_ff) && $stable(res_pw_ff))
    else $error("result changed outside averaging");
  a_cur_zero_uncal: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) reg_rd_i && !cal_wr_ff &&
    (reg_addr_i == pms_pkg::ADDR_CUR) |=> reg_rdata_o == 16'h0000)
    else $error("current nonzero before calibration");
  a_pwr_zero_uncal: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) reg_rd_i && !cal_wr_ff &&
    (reg_addr_i == pms_pkg::ADDR_PWR) |=> reg_rdata_o == 16'h0000)
    else $error("power nonzero before calibration");
  a_pd_no_convert: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    pd_mode |-> !send_req)
    else $error("conversion requested in power-down");
  a_single_stops: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_avg_step and !cfg_wr and !mode[pms_pkg::MODE_CONT_BIT] |=>
    !single_ff ##0 (cfg_wr or ##1 !send_req))
    else $error("single-shot cycle did not stop");
  a_bus_in_range: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    bus_raw_ff <= pms_pkg::BUS_MAX_CODE)
    else $error("bus code beyond full scale");
  a_bus_follows: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    send_bus && !cfg_wr |=> (state_ff == pms_pkg::ST_BUS) && busy_ff)
    else $error("bus conversion delayed after shunt");
  a_alert_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    aff_ff |=> alert_oe_o != $past(mask_ff[pms_pkg::MSK_ALERT_POLARITY]))
    else $error("alert pin level wrong");
  a_adc_start: assert property (@(posedge adc_clk_i)
    disable iff (!reset_n_i) rq_new |=> adc_start_o ##1 !adc_start_o)
    else $error("converter start not a single pulse");
endmodule

// *** logic/pms_pkg.sv ***
// Constants, types and helpers shared by the power monitor sequencer
package pms_pkg;
  localparam int DW = 16;
  localparam int AW = 8;
  // Register pointer values
  localparam logic [AW-1:0] ADDR_CFG = 8'h00;
  localparam logic [AW-1:0] ADDR_SHUNT = 8'h01;
  localparam logic [AW-1:0] ADDR_BUS = 8'h02;
  localparam logic [AW-1:0] ADDR_PWR = 8'h03;
  localparam logic [AW-1:0] ADDR_CUR = 8'h04;
  localparam logic [AW-1:0] ADDR_CAL = 8'h05;
  localparam logic [AW-1:0] ADDR_MASK = 8'h06;
  localparam logic [AW-1:0] ADDR_LIM = 8'h07;
  // Configuration fields
  localparam logic [DW-1:0] CFG_RESET = 16'h0127;
  localparam logic [DW-1:0] CFG_WR_MASK = 16'h0fff;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SCT_LSB = 3;
  localparam int CFG_BCT_LSB = 6;
  localparam int CFG_AVG_LSB = 9;
  localparam int MODE_SHUNT_BIT = 0;
  localparam int MODE_BUS_BIT = 1;
  localparam int MODE_CONT_BIT = 2;
  // Alert select and flag fields
  localparam int MSK_LEN = 0;
  localparam int MSK_ALERT_POLARITY = 1;
  localparam int MSK_CONVERSION_DONE_FLAG = 3;
  localparam int MSK_AFF = 4;
  localparam int MSK_READY_ON_ALERT_ENABLE = 10;
  localparam int MSK_POL = 11;
  localparam int MSK_BUL = 12;
  localparam int MSK_BOL = 13;
  localparam int MSK_SUL = 14;
  localparam int MSK_SOL = 15;
  localparam logic [DW-1:0] MSK_RESET = 16'h0000;
  localparam logic [DW-1:0] MSK_WR_MASK = 16'hfc03;
  // Bus voltage code weight and range
  localparam int BUS_LSB_UV = 1250;
  localparam int BUS_FS_MV = 40960;
  localparam logic [DW-1:0] BUS_MAX_CODE =
    16'(BUS_FS_MV * 1000 / BUS_LSB_UV - 1);
  // Arithmetic
  localparam int CUR_SHIFT = 11;
  localparam int PWR_SHIFT = 12;
  localparam int SEQ_W = 10;
  localparam int ACC_W = DW + SEQ_W;

  typedef struct packed {
    logic bus_chan;
    logic [2:0] conv_time;
  } pms_adc_req_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SHUNT = 3'b001,
    ST_BUS = 3'b011,
    ST_ACC = 3'b010,
    ST_AVG = 3'b110
  } pms_state_e;

  // Averaging code to log2 of the number of sequences
  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    case (code)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      default: avg_shift = 4'ha;
    endcase
  endfunction
endpackage

// *** dv/pms_adc_model.sv ***
// Behavioural converter answering start pulses on the link clock
`timescale 1ns/10ps
module pms_adc_model (
  input wire logic adc_clk_i, // Link clock
  input wire logic reset_n_i, // Async reset, active low
  input wire logic start_i, // Start pulse from the block
  input wire pms_pkg::pms_adc_req_s req_i, // Channel and time
  input wire logic slow_i, // Stretch each conversion
  input wire logic [15:0] shunt_i, // Shunt result to return
  input wire logic [15:0] bus_i, // Bus result to return
  output logic done_o, // Result pulse
  output logic [15:0] data_o, // Result word
  output logic [15:0] n_shunt_o, // Shunt starts seen
  output logic [15:0] n_bus_o // Bus starts seen
);
  logic busy_ff;
  logic chan_ff;
  logic [4:0] wait_ff;
  always_ff @(posedge adc_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      busy_ff <= 1'b0;
      chan_ff <= 1'b0;
      wait_ff <= 5'h00;
      done_o <= 1'b0;
      data_o <= 16'h0000;
      n_shunt_o <= 16'h0000;
      n_bus_o <= 16'h0000;
    end
    else
    begin
      done_o <= 1'b0;
      // Word is valid only with the pulse, so keep it moving otherwise
      data_o <= ~data_o;
      if (start_i)
      begin
        busy_ff <= 1'b1;
        chan_ff <= req_i.bus_chan;
        wait_ff <= slow_i ? 5'h14 : 5'h04;
        if (req_i.bus_chan)
          n_bus_o <= n_bus_o + 16'h0001;
        else
          n_shunt_o <= n_shunt_o + 16'h0001;
      end
      else if (busy_ff && wait_ff != 5'h00)
        wait_ff <= wait_ff - 5'h01;
      else if (busy_ff)
      begin
        busy_ff <= 1'b0;
        done_o <= 1'b1;
        data_o <= chan_ff ? bus_i : shunt_i;
      end
    end
  end
endmodule

// *** dv/tb.sv ***
// Register-level bench for the power monitor sequencer
`timescale 1ns/10ps
module tb;
  localparam logic [15:0] SH = 16'h0320;
  localparam logic [15:0] BU = 16'h2580;
  localparam logic [15:0] CAL = 16'h0a00;
  localparam logic [15:0] EC = 16'((32'(SH) * 32'(CAL)) >> 11);
  localparam logic [15:0] EP = 16'((32'(EC) * 32'(BU)) >> 12);
  logic clk_i = 1'b0;
  logic adc_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [15:0] reg_rdata_o;
  logic adc_start_o;
  pms_pkg::pms_adc_req_s adc_req_o;
  logic adc_done_i;
  logic [15:0] adc_data_i;
  logic alert_o;
  logic alert_oe_o;
  logic slow = 1'b0;
  logic [15:0] bus_v = BU;
  logic [15:0] n_sh;
  logic [15:0] n_bu;
  logic [15:0] d;
  logic [15:0] s0;
  logic [15:0] b0;
  int n_fail = 0;
  int total_checks = 0;
  logic [2:0] md [4] = '{3'h1, 3'h2, 3'h3, 3'h3};
  logic [2:0] pm [4] = '{3'h0, 3'h4, 3'h5, 3'h6};
  logic [15:0] tm [7] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
    16'h0800, 16'hc000, 16'h8002};
  logic [15:0] tl [7] = '{SH - 16'h1, SH + 16'h1, BU - 16'h1,
    BU + 16'h1, EP - 16'h1, SH + 16'h1, SH - 16'h1};
  logic [6:0] te = 7'h5f;
  logic [6:0] to = 7'h1f;

  always #25 clk_i = ~clk_i;
  always #62.5 adc_clk_i = ~adc_clk_i;

  pms_sequencer u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .adc_clk_i(adc_clk_i), .adc_start_o(adc_start_o),
    .adc_req_o(adc_req_o), .adc_done_i(adc_done_i),
    .adc_data_i(adc_data_i), .alert_o(alert_o), .alert_oe_o(alert_oe_o));

  pms_adc_model u_adc (.adc_clk_i(adc_clk_i), .reset_n_i(reset_n_i),
    .start_i(adc_start_o), .req_i(adc_req_o), .slow_i(slow),
    .shunt_i(SH), .bus_i(bus_v), .done_o(adc_done_i),
    .data_o(adc_data_i), .n_shunt_o(n_sh), .n_bus_o(n_bu));

  function automatic logic [15:0] cfg(input logic [2:0] a,
    input logic [2:0] m);
    return {4'h0, a, 6'h23, m};
  endfunction

  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Sample off the edge, after the alert pin has followed the flags
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    v = reg_rdata_o;
  endtask

  task automatic wait_done(output logic [15:0] m);
    int i;
    m = 16'h0000;
    for (i = 0; i < 3000 && m[pms_pkg::MSK_CONVERSION_DONE_FLAG] !== 1'b1; i++)
      rd(pms_pkg::ADDR_MASK, m);
    chk("done flag", 16'h1, 16'(m[pms_pkg::MSK_CONVERSION_DONE_FLAG]));
  endtask

  task automatic wait_oe();
    int i;
    for (i = 0; i < 4000 && alert_oe_o !== 1'b1; i++)
      @(negedge clk_i);
    chk("alert enable", 16'h1, 16'(alert_oe_o));
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #2000000;
    n_fail++;
    $display("unexpected run time: expected finish, seen none");
    close_out();
  end

  initial
  begin
    int i;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(pms_pkg::ADDR_CFG, d);
    chk("config", pms_pkg::CFG_RESET, d);
    rd(pms_pkg::ADDR_MASK, d);
    chk("mask", pms_pkg::MSK_RESET, d);
    rd(8'h08, d);
    chk("unmapped", 16'h0000, d);
    wr(pms_pkg::ADDR_PWR, 16'h1234);
    wait_done(d);
    chk("both run", 16'h1, 16'(n_sh != 0 && n_bu != 0));
    rd(pms_pkg::ADDR_CUR, d);
    chk("current", 16'h0000, d);
    rd(pms_pkg::ADDR_PWR, d);
    chk("power", 16'h0000, d);
    rd(pms_pkg::ADDR_SHUNT, d);
    chk("shunt", SH, d);
    wr(pms_pkg::ADDR_MASK, 16'hffff);
    rd(pms_pkg::ADDR_MASK, d);
    chk("mask bits", pms_pkg::MSK_WR_MASK, d & pms_pkg::MSK_WR_MASK);
    wr(pms_pkg::ADDR_MASK, 16'h0000);
    $display("test reset finished");
    wr(pms_pkg::ADDR_CAL, CAL);
    rd(pms_pkg::ADDR_CAL, d);
    chk("scale", CAL, d);
    wr(pms_pkg::ADDR_CFG, cfg(3'h0, 3'h0));
    repeat (200) @(posedge clk_i);
    for (i = 0; i < 4; i++)
    begin
      s0 = n_sh;
      b0 = n_bu;
      wr(pms_pkg::ADDR_CFG, cfg(3'h0, md[i]));
      wait_done(d);
      repeat (200) @(posedge clk_i);
      chk("shunt count", 16'(md[i][0]), n_sh - s0);
      chk("bus count", 16'(md[i][1]), n_bu - b0);
      chk("converter request", md[i][1] ? 16'h000c : 16'h0003,
        16'(adc_req_o));
    end
    rd(pms_pkg::ADDR_BUS, d);
    chk("bus", BU, d);
    rd(pms_pkg::ADDR_CUR, d);
    chk("current", EC, d);
    rd(pms_pkg::ADDR_PWR, d);
    chk("power", EP, d);
    $display("test single shot finished");
    s0 = n_sh;
    b0 = n_bu;
    wr(pms_pkg::ADDR_CFG, cfg(3'h1, 3'h3));
    wait_done(d);
    chk("shunt count", 16'h0004, n_sh - s0);
    chk("bus count", 16'h0004, n_bu - b0);
    rd(pms_pkg::ADDR_PWR, d);
    chk("power", EP, d);
    bus_v <= 16'hffff;
    wr(pms_pkg::ADDR_CFG, cfg(3'h0, 3'h2));
    wait_done(d);
    rd(pms_pkg::ADDR_BUS, d);
    chk("bus", pms_pkg::BUS_MAX_CODE, d);
    bus_v <= BU;
    $display("test averaging finished");
    for (i = 0; i < 4; i++)
    begin
      wr(pms_pkg::ADDR_CFG, cfg(3'h0, 3'h0));
      repeat (200) @(posedge clk_i);
      s0 = n_sh;
      b0 = n_bu;
      slow <= (i == 3);
      wr(pms_pkg::ADDR_CFG, cfg(3'h0, pm[i]));
      repeat (500) @(posedge clk_i);
      chk("shunt runs", 16'(pm[i] == 3'h5), 16'(n_sh - s0 > 2));
      chk("bus runs", 16'(pm[i] == 3'h6), 16'(n_bu - b0 > 2));
    end
    slow <= 1'b0;
    wr(pms_pkg::ADDR_CFG, cfg(3'h0, 3'h0));
    wr(pms_pkg::ADDR_LIM, 16'h5a5a);
    rd(pms_pkg::ADDR_LIM, d);
    chk("limit", 16'h5a5a, d);
    chk("alert data", 16'h0000, 16'(alert_o));
    $display("test modes finished");
    for (i = 0; i < 7; i++)
    begin
      wr(pms_pkg::ADDR_MASK, tm[i]);
      wr(pms_pkg::ADDR_LIM, tl[i]);
      wr(pms_pkg::ADDR_CFG, cfg(3'h0, 3'h3));
      wait_done(d);
      chk("event flag", 16'(te[i]), 16'(d[pms_pkg::MSK_AFF]));
      chk("alert pin", 16'(to[i]), 16'(alert_oe_o));
    end
    $display("test limits finished");
    wr(pms_pkg::ADDR_MASK, 16'h0400);
    wr(pms_pkg::ADDR_CFG, cfg(3'h0, 3'h3));
    wait_done(d);
    chk("alert pin", 16'h0, 16'(alert_oe_o));
    wr(pms_pkg::ADDR_CFG, cfg(3'h0, 3'h3));
    wait_oe();
    wr(pms_pkg::ADDR_CFG, cfg(3'h0, 3'h0));
    rd(pms_pkg::ADDR_MASK, d);
    chk("done kept", 16'h1, 16'(d[pms_pkg::MSK_CONVERSION_DONE_FLAG]));
    rd(pms_pkg::ADDR_MASK, d);
    chk("done read", 16'h0, 16'(d[pms_pkg::MSK_CONVERSION_DONE_FLAG]));
    chk("alert pin", 16'h0, 16'(alert_oe_o));
    wr(pms_pkg::ADDR_CFG, cfg(3'h0, 3'h3));
    wait_oe();
    wr(pms_pkg::ADDR_CFG, cfg(3'h0, 3'h3));
    rd(pms_pkg::ADDR_MASK, d);
    chk("done write", 16'h0, 16'(d[pms_pkg::MSK_CONVERSION_DONE_FLAG]));
    wait_done(d);
    $display("test ready alert finished");
    wr(pms_pkg::ADDR_MASK, 16'h8001);
    wr(pms_pkg::ADDR_LIM, SH - 16'h1);
    wr(pms_pkg::ADDR_CFG, cfg(3'h0, 3'h3));
    wait_oe();
    wr(pms_pkg::ADDR_LIM, SH + 16'h1);
    b0 = n_bu;
    wr(pms_pkg::ADDR_CFG, cfg(3'h0, 3'h3));
    for (i = 0; i < 3000 && n_bu == b0; i++)
      @(posedge clk_i);
    repeat (100) @(posedge clk_i);
    chk("latched pin", 16'h1, 16'(alert_oe_o));
    rd(pms_pkg::ADDR_MASK, d);
    chk("latched flag", 16'h1, 16'(d[pms_pkg::MSK_AFF]));
    rd(pms_pkg::ADDR_MASK, d);
    chk("flag cleared", 16'h0, 16'(d[pms_pkg::MSK_AFF]));
    chk("pin cleared", 16'h0, 16'(alert_oe_o));
    $display("test latch finished");
    close_out();
  end
endmodule
